// [flash_id_pkg.sv]
// Constants and types for the flash identification reader.
// Assumes one 25 MHz system clock; the flash itself has no clock.
// Behaviour
// - Programmer raises A9, sets A6/A1/A0
// - Sector index on upper bits for protection
// - Identification reachable by command, normal levels
// - ID read: select, gate low, strobe high
package flash_id_pkg;
   localparam int ADDR_W = 22;
   localparam int SECT_W = 7;
   localparam int SECT_LSB = 15;
   localparam int NUM_SECTORS = 128;
   localparam logic [23:0] BYTE_SECT_SPAN = 24'h010000;
   localparam logic [23:0] WORD_SECT_SPAN = 24'h008000;
   localparam int CLK_MHZ = 25;
   localparam int T_ACC_NS = 70;
   localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_NS = 35;
   localparam int WR_CYC = (WR_NS * CLK_MHZ + 999) / 1000;
   localparam logic [11:0] UNLOCK_A1 = 12'h555;
   localparam logic [11:0] UNLOCK_A2 = 12'h2AA;
   localparam logic [7:0] UNLOCK_D1 = 8'hAA;
   localparam logic [7:0] UNLOCK_D2 = 8'h55;
   localparam logic [7:0] AUTOSEL_CMD = 8'h90;
   localparam logic [7:0] RESET_CMD = 8'hF0;
   localparam logic [1:0] SEL_MFR = 2'h0;
   localparam logic [1:0] SEL_DEV1 = 2'h1;
   localparam logic [1:0] SEL_PROT = 2'h2;
   typedef struct packed {
      logic [1:0] sel;
      logic [SECT_W-1:0] sectorIndex;
      logic inSystem;
      logic byteMode;
   } id_req_s;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic ceN;
      logic oeN;
      logic weN;
      logic byteN;
      logic elevatedIdVoltage;
   } flash_pins_s;
endpackage

// [flash_id_host.sv]
// Host that reads identification codes from a parallel flash.
// Assumes the testbench resolves the data lines from dataOe.
module flash_id_host
   import flash_id_pkg::*;
#(
   parameter int ACCESS_CYCLES = ACC_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Request
   input wire logic reqValid,
   input id_req_s req,
   output logic reqReady,
   output logic [7:0] idData,
   output logic idValid,
   // Flash pins
   output flash_pins_s pins,
   input wire logic [15:0] dataIn,
   output logic [15:0] dataOut,
   output logic [15:0] dataOe
);
   // The read count loads ACCESS_CYCLES + 2 into an 8-bit counter
   if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 253) begin : g_bad_access
      $error("ACCESS_CYCLES out of range");
   end

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, ST_WRITE = 6'h02, ST_GAP = 6'h04,
      ST_READ = 6'h08, ST_EXIT = 6'h10, ST_DONE = 6'h20
   } state_e;

   state_e state_reg, state_next;
   id_req_s req_reg;
   logic [7:0] cnt_reg;
   logic [1:0] step_reg;
   logic [7:0] idData_reg;
   logic idValid_reg;
   logic [7:0] s1_reg, s2_reg, s3_reg;

   function automatic logic [ADDR_W-1:0] idAddr(input id_req_s r);
      logic [ADDR_W-1:0] a;
      a = '0;
      a[SECT_LSB +: SECT_W] = (r.sel == SEL_PROT) ? r.sectorIndex : '0;
      a[1] = (r.sel == SEL_PROT);
      a[0] = (r.sel == SEL_DEV1);
      a[9] = 1'b0;
      return a;
   endfunction

   // Command cycle address and data for the current step
   wire logic [11:0] cmdAddr = (step_reg == 2'h1) ? UNLOCK_A2 : UNLOCK_A1;
   wire logic [7:0] cmdData = (state_reg == ST_EXIT) ? RESET_CMD :
      (step_reg == 2'h0) ? UNLOCK_D1 : (step_reg == 2'h1) ? UNLOCK_D2 : AUTOSEL_CMD;
   wire logic lastStep = (step_reg == 2'h2) || (state_reg == ST_EXIT);
   wire logic cntDone = (cnt_reg == 8'h00);
   wire logic writing = (state_reg == ST_WRITE) || (state_reg == ST_EXIT);
   wire logic reading = (state_reg == ST_READ);
   // Low data byte only driven on writes, so reads find it floating
   wire logic driveData = writing;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (reqValid) state_next = req.inSystem ? ST_WRITE : ST_READ;
         ST_WRITE: if (cntDone) state_next = ST_GAP;
         ST_GAP: if (cntDone) state_next = lastStep ? ST_READ : ST_WRITE;
         ST_READ: if (cntDone) state_next = req_reg.inSystem ? ST_EXIT : ST_DONE;
         ST_EXIT: if (cntDone) state_next = ST_DONE;
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         step_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            cnt_reg <= (state_next == ST_READ) ? 8'(ACCESS_CYCLES + 2) : 8'(WR_CYC);
         end else if (!cntDone) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
         if (state_reg == ST_IDLE) begin
            step_reg <= 2'h0;
         end else if (state_reg == ST_GAP && cntDone && !lastStep) begin
            step_reg <= step_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         req_reg <= '0;
      end else if (state_reg == ST_IDLE && reqValid) begin
         req_reg <= req;
      end
   end

   // Three-stage synchroniser on the low data byte
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
         s3_reg <= 8'h00;
      end else begin
         s1_reg <= dataIn[7:0];
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         idData_reg <= 8'h00;
         idValid_reg <= 1'b0;
      end else begin
         idValid_reg <= 1'b0;
         if (reading && cntDone && s2_reg == s3_reg) begin
            idData_reg <= s3_reg;
         end
         if (state_reg == ST_DONE) begin
            idValid_reg <= 1'b1;
         end
      end
   end

   assign reqReady = (state_reg == ST_IDLE);
   assign idData = idData_reg;
   assign idValid = idValid_reg;

   // Flash pin drive
   always_comb begin
      pins.addr = writing ? {10'h000, cmdAddr} : idAddr(req_reg);
      pins.ceN = !(writing || reading);
      pins.oeN = !reading;
      pins.weN = !writing;
      pins.byteN = !req_reg.byteMode;
      pins.elevatedIdVoltage = reading && !req_reg.inSystem;
   end

   assign dataOut = {8'h00, cmdData};
   // In byte mode the top pin is an address input driven low outside ST_IDLE; 14..8 never driven
   assign dataOe = req_reg.byteMode ? {(state_reg != ST_IDLE), 7'h00, {8{driveData}}}
                                    : {8'h00, {8{driveData}}};
endmodule

// [flash_dev_model.sv]
// Flash model: identification readout.
// Assumes the bench feeds sys_clk for the float pattern.
module flash_dev_model
   import flash_id_pkg::*;
#(
   parameter logic [7:0] MFR = 8'h11, // Arbitrary
   parameter logic [7:0] DEV = 8'h22, // Arbitrary
   parameter logic [6:0] PROT = 7'h05,
   parameter int ACC_NS = 60
) (
   input wire logic sys_clk,
   input flash_pins_s pins,
   input wire logic [15:0] dataOut,
   input wire logic [15:0] dataOe,
   output logic [15:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idMode = 1'b0;
   logic [1:0] step = 2'h0;
   logic [7:0] wd = 8'h00;
   logic [7:0] code;
   logic [15:0] junk = 16'h5A5A;
   always @(posedge sys_clk) junk <= ~junk;
   always @(posedge sys_clk) if (!pins.weN) wd <= dataOut[7:0];
   always @(posedge pins.weN) begin
      step <= (wd == UNLOCK_D1) ? 2'h1 : (wd == UNLOCK_D2 && step == 2'h1) ? 2'h2 : 2'h0;
      if (step == 2'h2 && wd == AUTOSEL_CMD) idMode <= 1'b1;
      if (wd == RESET_CMD) idMode <= 1'b0;
   end
   // Sector is A21..A15 in both widths; other bits ignored
   assign #(ACC_NS) code = !(idMode || pins.elevatedIdVoltage) ? ~pins.addr[7:0]
      : (pins.addr[1:0] == 2'h0) ? MFR : (pins.addr[1:0] == 2'h1) ? DEV
      : {7'h00, pins.addr[21:15] == PROT};
   always_comb begin
      dataIn = junk;
      if (!pins.ceN && !pins.oeN && pins.weN) dataIn = {pins.byteN ? 8'h00 : junk[15:8], code};
      for (int i = 0; i < 16; i++) if (dataOe[i]) dataIn[i] = dataOut[i];
   end
endmodule

// [flash_id_host_assertions.sv]
// Checker for the identification host pins.
// Assumes it is bound onto flash_id_host.
module flash_id_host_assertions
   import flash_id_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reqValid,
   input id_req_s req,
   input wire logic reqReady,
   input wire logic [7:0] idData,
   input wire logic idValid,
   input flash_pins_s pins,
   input wire logic [15:0] dataIn,
   input wire logic [15:0] dataOut,
   input wire logic [15:0] dataOe
);
   logic [6:0] sectReg;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) sectReg <= 7'h00;
      else if (reqValid && reqReady) sectReg <= req.sectorIndex;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_elev_sel_lines: assert property (pins.elevatedIdVoltage |-> !pins.addr[6] && pins.addr[1:0] != 2'h3)
      else $error("bad select lines");
   a_prot_sector: assert property (!pins.oeN && pins.addr[1:0] == 2'h2 |-> pins.addr[21:15] == sectReg)
      else $error("bad sector on address");
   a_write_levels: assert property (!pins.weN |-> pins.oeN && !pins.ceN && !pins.elevatedIdVoltage)
      else $error("bad write levels");
   a_read_levels: assert property (!pins.oeN |-> !pins.ceN && pins.weN && dataOe[14:0] == 15'h0000)
      else $error("bad read levels");
   c_answer: cover property (idValid);
   c_write: cover property (!pins.weN);
   c_elev: cover property (pins.elevatedIdVoltage && !pins.oeN);
endmodule
bind flash_id_host flash_id_host_assertions u_flash_id_host_assertions (.sys_clk, .nrst, .reqValid, .req,
   .reqReady, .idData, .idValid, .pins, .dataIn, .dataOut, .dataOe);

// [flash_id_host_bench.sv]
// Bench: host reads codes from the flash model.
// Assumes model and checker are compiled first.
module flash_id_host_bench
   import flash_id_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic reqValid = 1'b0;
   id_req_s req = '0;
   logic reqReady, idValid;
   logic [7:0] idData;
   flash_pins_s pins;
   logic [15:0] dataIn, dataOut, dataOe;
   int failures = 0;
   int cmp_count = 0;
   always #20 sys_clk = ~sys_clk;
   flash_id_host u_flash_id_host (.sys_clk, .nrst, .reqValid, .req, .reqReady, .idData, .idValid, .pins,
      .dataIn, .dataOut, .dataOe);
   flash_dev_model #(.MFR(8'h3C), .DEV(8'hA7), .PROT(7'h05)) u_flash_dev_model (.sys_clk, .pins, .dataOut,
      .dataOe, .dataIn);
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic ask(input logic [1:0] s, input logic [6:0] n, input logic sys, input logic bm,
      input logic [7:0] exp);
      int k;
      @(posedge sys_clk);
      req <= '{s, n, sys, bm};
      reqValid <= 1'b1;
      @(posedge sys_clk);
      reqValid <= 1'b0;
      for (k = 0; k < 300 && idValid !== 1'b1; k++) @(negedge sys_clk);
      cmp_count++;
      if (k == 300 || idData !== exp) begin
         failures++;
         $display("wrong value idData expected %h seen %h", exp, idData);
      end
      if (k == 300) wrap_up();
   endtask
   task automatic elevated_codes;
      ask(SEL_MFR, 7'h7F, 1'b0, 1'b0, 8'h3C);
      ask(SEL_DEV1, 7'h00, 1'b0, 1'b0, 8'hA7);
   endtask
   task automatic command_codes;
      ask(SEL_DEV1, 7'h00, 1'b1, 1'b1, 8'hA7);
      ask(SEL_MFR, 7'h00, 1'b1, 1'b0, 8'h3C);
   endtask
   task automatic protect_status;
      ask(SEL_PROT, 7'h05, 1'b0, 1'b1, 8'h01);
      ask(SEL_PROT, 7'h04, 1'b1, 1'b0, 8'h00);
      ask(SEL_PROT, 7'h7F, 1'b0, 1'b0, 8'h00);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      elevated_codes();
      command_codes();
      protect_status();
      wrap_up();
   end
endmodule
